//--- hw/pix_pack_pkg.sv
// constants shared by the pixel packing front end
package pix_pack_pkg;
   localparam int unsigned TYPE_W  = 6;
   localparam int unsigned DATA_W  = 64;
   localparam int unsigned CNT_W   = 4;
   localparam int unsigned BITS_W  = 7;
   localparam int unsigned LEN_W   = 13;
   localparam int unsigned VC_W    = 2;
   localparam int unsigned LINE_W  = 16;
   localparam int unsigned COMP_W  = 5;
   localparam int unsigned SLOTS   = 32;
   localparam int unsigned ADDR_W  = 5;
   // type codes
   localparam logic [5:0] DT_YUV420_8    = 6'h18;
   localparam logic [5:0] DT_YUV420_10   = 6'h19;
   localparam logic [5:0] DT_YUV420_8L   = 6'h1a;
   localparam logic [5:0] DT_YUV420_8C   = 6'h1c;
   localparam logic [5:0] DT_YUV420_10C  = 6'h1d;
   localparam logic [5:0] DT_YUV422_8    = 6'h1e;
   localparam logic [5:0] DT_YUV422_10   = 6'h1f;
   localparam logic [5:0] DT_RGB444      = 6'h20;
   localparam logic [5:0] DT_RGB555      = 6'h21;
   localparam logic [5:0] DT_RGB565      = 6'h22;
   localparam logic [5:0] DT_RGB666      = 6'h23;
   localparam logic [5:0] DT_RGB888      = 6'h24;
   localparam logic [5:0] DT_RAW6        = 6'h28;
   localparam logic [5:0] DT_RAW7        = 6'h29;
   localparam logic [5:0] DT_RAW8        = 6'h2a;
   localparam logic [5:0] DT_RAW10       = 6'h2b;
   localparam logic [5:0] DT_RAW12       = 6'h2c;
   localparam logic [5:0] DT_RAW14       = 6'h2d;
   localparam logic [5:0] DT_USER_LO     = 6'h30;
   localparam logic [5:0] DT_USER_HI     = 6'h37;
   // per-clock bit counts
   localparam logic [6:0] BITS_40 = 7'h28;
   localparam logic [6:0] BITS_48 = 7'h30;
   localparam logic [6:0] BITS_54 = 7'h36;
   localparam logic [6:0] BITS_56 = 7'h38;
   localparam logic [6:0] BITS_60 = 7'h3c;
   localparam logic [6:0] BITS_64 = 7'h40;
   // pixels per clock
   localparam logic [3:0] PIX_2  = 4'h2;
   localparam logic [3:0] PIX_3  = 4'h3;
   localparam logic [3:0] PIX_4  = 4'h4;
   localparam logic [3:0] PIX_5  = 4'h5;
   localparam logic [3:0] PIX_6  = 4'h6;
   localparam logic [3:0] PIX_8  = 4'h8;
   localparam logic [3:0] PIX_10 = 4'ha;
   // line length limits in pixels
   localparam logic [12:0] LEN_1920 = 13'h0780;
   localparam logic [12:0] LEN_2304 = 13'h0900;
   localparam logic [12:0] LEN_2556 = 13'h09fc;
   localparam logic [12:0] LEN_2880 = 13'h0b40;
   localparam logic [12:0] LEN_3288 = 13'h0cd8;
   localparam logic [12:0] LEN_3840 = 13'h0f00;
   localparam logic [12:0] LEN_4608 = 13'h1200;
   localparam logic [12:0] LEN_5760 = 13'h1680;
   localparam logic [12:0] LEN_6576 = 13'h19b0;
   localparam logic [12:0] LEN_7680 = 13'h1e00;
   // pixel widths in bits
   localparam logic [4:0] W_6  = 5'h06;
   localparam logic [4:0] W_7  = 5'h07;
   localparam logic [4:0] W_8  = 5'h08;
   localparam logic [4:0] W_10 = 5'h0a;
   localparam logic [4:0] W_12 = 5'h0c;
   localparam logic [4:0] W_14 = 5'h0e;
   localparam logic [4:0] W_15 = 5'h0f;
   localparam logic [4:0] W_16 = 5'h10;
   localparam logic [4:0] W_18 = 5'h12;
   localparam logic [4:0] W_24 = 5'h18;
   // controller states, gray coded
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_LINE  = 2'b11,
      ST_GAP   = 2'b10
   } line_state_t;
endpackage : pix_pack_pkg

//--- hw/pix_word_mem.sv
// small register-output memory holding raw pixel words of one line group
`timescale 1ns/1ps
`default_nettype none
module pix_word_mem (
   input  wire logic                                clk_sys,
   input  wire logic                                wr_en,
   input  wire logic [pix_pack_pkg::ADDR_W-1:0]     wr_addr,
   input  wire logic [pix_pack_pkg::DATA_W-1:0]     wr_data,
   input  wire logic [pix_pack_pkg::ADDR_W-1:0]     rd_addr,
   output logic      [pix_pack_pkg::DATA_W-1:0]     rd_data
);
   import pix_pack_pkg::*;
   logic [DATA_W-1:0] mem_r [SLOTS];

   // write port
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // registered read
   always_ff @(posedge clk_sys) begin
      rd_data <= mem_r[rd_addr];
   end
endmodule : pix_word_mem
`default_nettype wire

//--- hw/pix_type_host.sv
// core-side driver of the transmitter pixel port: type, sync, channel, packed data
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: type code changes only while horizontal sync is low.
// R2: type code is held one pixel clock before horizontal sync rises.
// R3: channel id changes with vertical sync low, held one clock before it rises.
// R4: 0x20 RGB444, 48 bits, four 12-bit pixels, 2880 per line.
// R5: 0x21 RGB555, 60 bits, four 15-bit pixels, 2880 per line.
// R6: 0x22 RGB565, 64 bits, four 16-bit pixels, 2880 per line.
// R7: 0x23 RGB666, 54 bits, three 18-bit pixels, 2556 per line.
// R8: 0x24 RGB888, 48 bits, two 24-bit pixels, 1920 per line.
// R9: 0x28 RAW6, 60 bits, ten 6-bit pixels, 7680 per line.
// R10: 0x29 RAW7, 56 bits, eight 7-bit pixels, 6576 per line.
// R11: 0x2A RAW8, 64 bits, eight 8-bit pixels, 5760 per line.
// R12: 0x2B RAW10, 60 bits, six 10-bit pixels, 4608 per line.
// R13: 0x2C RAW12, 60 bits, five 12-bit pixels, 3840 per line.
// R14: 0x2D RAW14, 56 bits, four 14-bit pixels, 3288 per line.
// R15: 0x18/0x1C YUV420 8-bit, odd lines eight, even four pixels, 2880.
// R16: 0x19/0x1D YUV420 10-bit, odd six in 60, even two in 40, 2304.
// R17: 0x1A legacy YUV420 8-bit, four pixels in 48 bits, 3840.
// R18: 0x1E YUV422 8-bit, four pixels in 64 bits, 2880.
// R19: 0x1F YUV422 10-bit, two pixels in 40 bits, 2304.
// R20: 0x30 to 0x37 user 8-bit, eight pixels in 64 bits, 5760.
// R21: valid bits sit at the low end; bits above the count are zero.
module pix_type_host (
   input  wire logic                                clk_sys,
   input  wire logic                                reset_n,
   input  wire logic                                line_start,
   input  wire logic                                frame_start,
   input  wire logic                                frame_end,
   input  wire logic [pix_pack_pkg::TYPE_W-1:0]     req_type,
   input  wire logic [pix_pack_pkg::VC_W-1:0]       req_vc,
   input  wire logic [pix_pack_pkg::LEN_W-1:0]      req_len,
   input  wire logic                                src_valid,
   input  wire logic [pix_pack_pkg::DATA_W-1:0]     src_data,
   output logic                                     src_ready,
   output logic                                     busy,
   output logic                                     type_bad,
   output logic                                     len_bad,
   output logic [pix_pack_pkg::BITS_W-1:0]          bits_per_clk,
   output logic [pix_pack_pkg::CNT_W-1:0]           pix_per_clk,
   output logic [pix_pack_pkg::TYPE_W-1:0]          video_type,
   output logic [pix_pack_pkg::VC_W-1:0]            virtual_channel_id,
   output logic                                     hsync,
   output logic                                     vsync,
   output logic                                     pix_valid,
   output logic [pix_pack_pkg::DATA_W-1:0]          pix_data
);
   import pix_pack_pkg::*;

   line_state_t        state_r;
   line_state_t        state_nxt;
   logic [TYPE_W-1:0]  type_r;
   logic [LEN_W-1:0]   left_r;
   logic               odd_line_r;
   logic [BITS_W-1:0]  bits_sel;
   logic [CNT_W-1:0]   pix_sel;
   logic [LEN_W-1:0]   max_sel;
   logic               known_sel;
   logic [DATA_W-1:0]  keep_mask;
   logic [DATA_W-1:0]  mem_rd;
   logic [ADDR_W-1:0]  wr_ptr_r;
   logic               take;
   logic               last_beat;

   // format table: bit count, pixel count and line limit per type code
   always_comb begin
      bits_sel  = BITS_64;
      pix_sel   = PIX_8;
      max_sel   = LEN_5760;
      known_sel = 1'b1;
      if (type_r >= DT_USER_LO && type_r <= DT_USER_HI) begin
         bits_sel = BITS_64;                                  // [R20]
         pix_sel  = PIX_8;
         max_sel  = LEN_5760;
      end else begin
         unique case (type_r)
            DT_RGB444: begin bits_sel = BITS_48; pix_sel = PIX_4; max_sel = LEN_2880; end // [R4]
            DT_RGB555: begin bits_sel = BITS_60; pix_sel = PIX_4; max_sel = LEN_2880; end // [R5]
            DT_RGB565: begin bits_sel = BITS_64; pix_sel = PIX_4; max_sel = LEN_2880; end // [R6]
            DT_RGB666: begin bits_sel = BITS_54; pix_sel = PIX_3; max_sel = LEN_2556; end // [R7]
            DT_RGB888: begin bits_sel = BITS_48; pix_sel = PIX_2; max_sel = LEN_1920; end // [R8]
            DT_RAW6:   begin bits_sel = BITS_60; pix_sel = PIX_10; max_sel = LEN_7680; end // [R9]
            DT_RAW7:   begin bits_sel = BITS_56; pix_sel = PIX_8; max_sel = LEN_6576; end // [R10]
            DT_RAW8:   begin bits_sel = BITS_64; pix_sel = PIX_8; max_sel = LEN_5760; end // [R11]
            DT_RAW10:  begin bits_sel = BITS_60; pix_sel = PIX_6; max_sel = LEN_4608; end // [R12]
            DT_RAW12:  begin bits_sel = BITS_60; pix_sel = PIX_5; max_sel = LEN_3840; end // [R13]
            DT_RAW14:  begin bits_sel = BITS_56; pix_sel = PIX_4; max_sel = LEN_3288; end // [R14]
            DT_YUV420_8, DT_YUV420_8C: begin                  // [R15]
               bits_sel = BITS_64;
               pix_sel  = odd_line_r ? PIX_8 : PIX_4;
               max_sel  = LEN_2880;
            end
            DT_YUV420_10, DT_YUV420_10C: begin                // [R16]
               bits_sel = odd_line_r ? BITS_60 : BITS_40;
               pix_sel  = odd_line_r ? PIX_6 : PIX_2;
               max_sel  = LEN_2304;
            end
            DT_YUV420_8L: begin bits_sel = BITS_48; pix_sel = PIX_4; max_sel = LEN_3840; end // [R17]
            DT_YUV422_8:  begin bits_sel = BITS_64; pix_sel = PIX_4; max_sel = LEN_2880; end // [R18]
            DT_YUV422_10: begin bits_sel = BITS_40; pix_sel = PIX_2; max_sel = LEN_2304; end // [R19]
            default: begin
               known_sel = 1'b0;
            end
         endcase
      end
   end

   // low-end mask: one bit per valid position
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_mask
         assign keep_mask[gi] = (BITS_W'(gi) < bits_sel);    // [R21]
      end
   endgenerate

   // line sequencer: idle, type setup, active line, line gap
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (line_start) state_nxt = ST_SETUP;
         ST_SETUP: state_nxt = ST_LINE;                       // [R2]
         ST_LINE:  if (last_beat) state_nxt = ST_GAP;
         ST_GAP:   state_nxt = ST_IDLE;
      endcase
   end

   assign take      = (state_r == ST_LINE) && src_valid;
   assign src_ready = (state_r == ST_LINE);
   assign last_beat = take && (left_r <= LEN_W'(pix_sel));
   assign busy      = (state_r != ST_IDLE);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // type code latched only while the line is not running
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         type_r <= DT_RAW8;
      end else if (state_r == ST_IDLE && line_start) begin
         type_r <= req_type;                                  // [R1]
      end
   end

   // remaining pixels in the line, clamped to the type limit
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         left_r  <= '0;
         len_bad <= 1'b0;
      end else if (state_r == ST_SETUP) begin
         left_r  <= (req_len > max_sel) ? max_sel : req_len;
         len_bad <= (req_len > max_sel);
      end else if (take) begin
         left_r  <= last_beat ? '0 : left_r - LEN_W'(pix_sel);
      end
   end

   // odd/even line parity, reset on frame start while vsync is low
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         odd_line_r <= 1'b1;
      end else if (frame_start && !vsync) begin
         odd_line_r <= 1'b1;
      end else if (state_r == ST_GAP) begin
         odd_line_r <= !odd_line_r;
      end
   end

   // vertical sync and channel id
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         vsync              <= 1'b0;
         virtual_channel_id <= '0;
      end else if (!vsync && frame_start) begin
         virtual_channel_id <= req_vc;                        // [R3]
      end else if (!vsync && virtual_channel_id == req_vc && frame_start == 1'b0
                   && state_r == ST_SETUP) begin
         vsync <= 1'b1;                                       // [R3]
      end else if (vsync && frame_end && state_r == ST_IDLE) begin
         vsync <= 1'b0;
      end
   end

   // horizontal sync high only during the active line
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hsync <= 1'b0;
      end else begin
         hsync <= (state_nxt == ST_LINE);                     // [R2]
      end
   end

   // record of recent raw words for inspection of the last line group
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= '0;
      end else if (take) begin
         wr_ptr_r <= wr_ptr_r + ADDR_W'(1);
      end
   end

   pix_word_mem u_mem (
      .clk_sys (clk_sys),
      .wr_en   (take),
      .wr_addr (wr_ptr_r),
      .wr_data (src_data),
      .rd_addr (wr_ptr_r),
      .rd_data (mem_rd)
   );

   // registered pixel output and status
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pix_valid    <= 1'b0;
         pix_data     <= '0;
         bits_per_clk <= '0;
         pix_per_clk  <= '0;
         video_type   <= DT_RAW8;
         type_bad     <= 1'b0;
      end else begin
         pix_valid    <= take;
         pix_data     <= take ? (src_data & keep_mask) : '0; // [R21]
         bits_per_clk <= bits_sel;
         pix_per_clk  <= pix_sel;
         // type leaves with the latch edge so it settles a clock before hsync rises
         video_type   <= (state_r == ST_IDLE && line_start) ? req_type : type_r; // [R1][R2]
         type_bad     <= !known_sel;
      end
   end
endmodule : pix_type_host
`default_nettype wire

//--- testbench/tx_pixel_port_model.sv
// behavioural transmitter pixel port: format table, parity and input order checks
`timescale 1ns/1ps
`default_nettype none
module tx_pixel_port_model (
   input  wire logic                            clk_sys,
   input  wire logic                            reset_n,
   input  wire logic [pix_pack_pkg::TYPE_W-1:0] video_type,
   input  wire logic [pix_pack_pkg::VC_W-1:0]   virtual_channel_id,
   input  wire logic                            hsync,
   input  wire logic                            vsync,
   input  wire logic [pix_pack_pkg::DATA_W-1:0] pix_data,
   output logic      [6:0]                      exp_bits,
   output logic      [3:0]                      exp_ppc,
   output int                                   rule_errs,
   output logic      [pix_pack_pkg::DATA_W-1:0] line_word
);
   import pix_pack_pkg::*;
   logic              odd_r;
   logic              hs_r;
   logic              vs_r;
   logic [TYPE_W-1:0] type_r;
   logic [VC_W-1:0]   vc_r;
   // per-clock bit count and pixel count of the selected code
   always_comb begin
      {exp_ppc, exp_bits} = {4'h0, 7'h40};
      case (video_type)
         6'h20, 6'h21, 6'h22: {exp_ppc, exp_bits} = {4'h4, video_type[1] ? 7'h40 : video_type[0] ? 7'h3c : 7'h30};
         6'h23: {exp_ppc, exp_bits} = {4'h3, 7'h36};
         6'h24: {exp_ppc, exp_bits} = {4'h2, 7'h30};
         6'h28: {exp_ppc, exp_bits} = {4'ha, 7'h3c};
         6'h29: {exp_ppc, exp_bits} = {4'h8, 7'h38};
         6'h2a: {exp_ppc, exp_bits} = {4'h8, 7'h40};
         6'h2b: {exp_ppc, exp_bits} = {4'h6, 7'h3c};
         6'h2c: {exp_ppc, exp_bits} = {4'h5, 7'h3c};
         6'h2d: {exp_ppc, exp_bits} = {4'h4, 7'h38};
         6'h18, 6'h1c: {exp_ppc, exp_bits} = {odd_r ? 4'h8 : 4'h4, 7'h40};
         6'h19, 6'h1d: {exp_ppc, exp_bits} = odd_r ? {4'h6, 7'h3c} : {4'h2, 7'h28};
         6'h1a: {exp_ppc, exp_bits} = {4'h4, 7'h30};
         6'h1e: {exp_ppc, exp_bits} = {4'h4, 7'h40};
         6'h1f: {exp_ppc, exp_bits} = {4'h2, 7'h28};
         6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37: {exp_ppc, exp_bits} = {4'h8, 7'h40};
         default: ;
      endcase
   end
   // bits above the count are dropped by the port
   assign line_word = (exp_bits == 7'h40) ? pix_data : pix_data & ((64'h1 << exp_bits) - 64'h1);
   // parity follows frame and line syncs; type is watched while hsync is high or just fell, channel while vsync is high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {odd_r, hs_r, vs_r, type_r, vc_r, rule_errs} <= '0;
         type_r <= 6'h2a;
      end else begin
         {hs_r, vs_r, type_r, vc_r} <= {hsync, vsync, video_type, virtual_channel_id};
         if (vsync && !vs_r) odd_r <= 1'b1;
         else if (hs_r && !hsync) odd_r <= !odd_r;
         if ((hsync || hs_r) && video_type != type_r) rule_errs <= rule_errs + 1;
         if (vsync && virtual_channel_id != vc_r) rule_errs <= rule_errs + 1;
      end
   end
endmodule : tx_pixel_port_model
`default_nettype wire

//--- testbench/pix_type_host_asserts.sv
// concurrent checks on the ports of the pixel packing front end
`timescale 1ns/1ps
`default_nettype none
module pix_type_host_asserts (
   input  wire logic                            clk_sys,
   input  wire logic                            reset_n,
   input  wire logic                            line_start,
   input  wire logic                            src_valid,
   input  wire logic                            src_ready,
   input  wire logic                            busy,
   input  wire logic [pix_pack_pkg::BITS_W-1:0] bits_per_clk,
   input  wire logic [pix_pack_pkg::CNT_W-1:0]  pix_per_clk,
   input  wire logic [pix_pack_pkg::TYPE_W-1:0] video_type,
   input  wire logic [pix_pack_pkg::VC_W-1:0]   virtual_channel_id,
   input  wire logic                            hsync,
   input  wire logic                            vsync,
   input  wire logic                            pix_valid,
   input  wire logic [pix_pack_pkg::DATA_W-1:0] pix_data
);
   import pix_pack_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // line request and the sync rise that answers it
   sequence s_line_req; line_start && !busy; endsequence
   sequence s_sync_up; ##2 ($rose(hsync) && $stable(video_type)); endsequence
   a_type_hold_line: assert property ($past(hsync) |-> $stable(video_type))
      else $error("type changed during line sync");
   a_type_before_sync: assert property ($rose(hsync) |-> $stable(video_type))
      else $error("type not settled before line sync");
   a_line_to_sync: assert property (s_line_req |-> s_sync_up)
      else $error("line sync late or type moving");
   a_vc_hold_frame: assert property (vsync |-> $stable(virtual_channel_id))
      else $error("channel moved near frame sync");
   a_data_masked: assert property (pix_valid |-> (pix_data >> bits_per_clk) == '0)
      else $error("bits above count not clear");
   a_beat_echo: assert property (src_valid && src_ready |=> pix_valid)
      else $error("taken beat not passed on");
   a_rgb666_fmt: assert property (hsync && video_type == DT_RGB666 |-> bits_per_clk == BITS_54 && pix_per_clk == PIX_3)
      else $error("rgb666 format wrong");
   a_rgb888_fmt: assert property (hsync && video_type == DT_RGB888 |-> bits_per_clk == BITS_48 && pix_per_clk == PIX_2)
      else $error("rgb888 format wrong");
   a_raw6_fmt: assert property (hsync && video_type == DT_RAW6 |-> bits_per_clk == BITS_60 && pix_per_clk == PIX_10)
      else $error("raw6 format wrong");
   a_yuv422_fmt: assert property (hsync && video_type == DT_YUV422_10 |-> bits_per_clk == BITS_40 && pix_per_clk == PIX_2)
      else $error("yuv422 10-bit format wrong");
endmodule : pix_type_host_asserts
bind pix_type_host pix_type_host_asserts chk_u (.clk_sys, .reset_n, .line_start, .src_valid,
   .src_ready, .busy, .bits_per_clk, .pix_per_clk, .video_type, .virtual_channel_id, .hsync,
   .vsync, .pix_valid, .pix_data);
`default_nettype wire

//--- testbench/pix_type_host_tb.sv
// self-checking bench for the pixel packing front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pix_type_host_tb;
   import pix_pack_pkg::*;
   logic              clk_sys, reset_n, line_start, frame_start, frame_end, src_valid;
   logic              src_ready, busy, type_bad, len_bad, hsync, vsync, pix_valid;
   logic [5:0]        req_type, video_type;
   logic [1:0]        req_vc, virtual_channel_id;
   logic [12:0]       req_len;
   logic [63:0]       src_data, pix_data, line_word;
   logic [6:0]        bits_per_clk, exp_bits;
   logic [3:0]        pix_per_clk, exp_ppc;
   int                fail_count, total_checks, rule_errs, cyc;
   logic [5:0] codes [24] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h28, 6'h29, 6'h2a, 6'h2b,
      6'h2c, 6'h2d, 6'h1a, 6'h18, 6'h18, 6'h19, 6'h19, 6'h1c, 6'h1c, 6'h1d, 6'h1d, 6'h1e, 6'h1f,
      6'h30, 6'h37};
   int beats [24] = '{8, 8, 8, 10, 15, 3, 4, 4, 5, 6, 8, 8, 4, 8, 5, 15, 4, 8, 5, 15, 8, 15, 4, 4};
   pix_type_host dut_u (.clk_sys, .reset_n, .line_start, .frame_start, .frame_end, .req_type,
      .req_vc, .req_len, .src_valid, .src_data, .src_ready, .busy, .type_bad, .len_bad,
      .bits_per_clk, .pix_per_clk, .video_type, .virtual_channel_id, .hsync, .vsync, .pix_valid,
      .pix_data);
   tx_pixel_port_model p_u (.clk_sys, .reset_n, .video_type, .virtual_channel_id, .hsync, .vsync,
      .pix_data, .exp_bits, .exp_ppc, .rule_errs, .line_word);
   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc >= 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // close any frame and open a new one on the given channel
   task automatic new_frame(input logic [1:0] vc);
      @(posedge clk_sys);
      frame_end <= 1'b1;
      @(posedge clk_sys);
      frame_end <= 1'b0;
      req_vc <= vc;
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
   endtask : new_frame
   // send one line of all-ones beats and judge format, masking and beat count
   task automatic run_line(input logic [5:0] t, input logic [12:0] len, input int nb,
                           input logic lbad);
      int n;
      logic [63:0] m;
      n = 0;
      @(posedge clk_sys);
      req_type <= t;
      req_len <= len;
      line_start <= 1'b1;
      @(posedge clk_sys);
      line_start <= 1'b0;
      src_valid <= 1'b1;
      for (int k = 0; k < 2000; k++) begin
         // look only once the edge has settled; stop when the line has gone idle
         @(negedge clk_sys);
         if (busy !== 1'b1) break;
         if (pix_valid === 1'b1) begin
            m = (exp_bits == 7'h40) ? '1 : (64'h1 << exp_bits) - 64'h1;
            if (n == 0) begin
               `CHK("type", t, video_type)
               `CHK("bits", exp_bits, bits_per_clk)
               `CHK("pixels", exp_ppc, pix_per_clk)
               `CHK("syncs", 2'b11, {hsync, vsync})
               `CHK("ready", 1'b1, src_ready)
            end
            `CHK("data", m, pix_data)
            `CHK("port word", line_word, pix_data)
            n++;
         end
      end
      `CHK("ready idle", 1'b0, src_ready)
      `CHK("type flag", 1'b0, type_bad)
      @(posedge clk_sys);
      src_valid <= 1'b0;
      `CHK("beats", nb, n)
      `CHK("len flag", lbad, len_bad)
   endtask : run_line
   // every listed code in one frame, parity alternating line by line
   task automatic all_codes();
      new_frame(2'h2);
      foreach (codes[i]) run_line(codes[i], 13'd30, beats[i], 1'b0);
      `CHK("channel", 2'h2, virtual_channel_id)
   endtask : all_codes
   // line length at and beyond the rgb888 limit on another channel
   task automatic len_limit();
      new_frame(2'h1);
      run_line(DT_RGB888, 13'd1920, 960, 1'b0);
      run_line(DT_RGB888, 13'd1921, 960, 1'b1);
      `CHK("channel", 2'h1, virtual_channel_id)
      `CHK("sync order", 0, rule_errs)
   endtask : len_limit
   initial begin
      {reset_n, line_start, frame_start, frame_end, src_valid, req_vc} = '0;
      {req_type, req_len, fail_count, total_checks, cyc} = '0;
      src_data = '1;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      `CHK("reset type", 6'h2a, video_type)
      `CHK("reset sync", 2'b00, {hsync, vsync})
      all_codes();
      len_limit();
      print_verdict();
   end
endmodule : pix_type_host_tb
`default_nettype wire
